// ---- src/irc_top.sv ----
// ir carrier output: transmission down counter, carrier gating and register slave
//
// Added by the designer: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "irc_map.svh"

module irc_top
  import irc_pkg::*;
(
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // avalon-mm slave
  input wire logic [3:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  // pins
  output logic IR_OUTPUT_PIN_OUT,
  output logic SENSE_INDICATOR_PIN_N_OUT
);

  // ****************************************************************
  // derived cycle counts
  // ****************************************************************

  // the clock stands for twice the system rate, so one system period is two clocks
  localparam int unsigned DEC_CLK = `IRC_DEC_FX * `IRC_CLK_PER_FX;
  localparam logic [7:0] PRESC_RELOAD = 8'(DEC_CLK - 1);
  // the first step carries the extra period of (set value + 1), half a period in high speed, less the start loss;
  // a count of one still gives a full step, at the cost of an 8-bit prescaler
  localparam logic [7:0] FIRST_NORM =
    8'((2 * `IRC_DEC_FX - `IRC_LOSS_NORM_FX) * `IRC_CLK_PER_FX - 1);
  localparam logic [7:0] FIRST_HS =
    8'((`IRC_DEC_FX + `IRC_HS_HALF_FX - `IRC_LOSS_HS_FX) * `IRC_CLK_PER_FX - 1);

  irc_top_st_t st_q;
  irc_top_st_t st_d;
  logic car_level;
  logic car_hi_end;
  logic wr_fire;
  logic [31:0] rd_mux;
  logic [31:0] wd;

  // ****************************************************************
  // helpers
  // ****************************************************************

  // byte-lane merge so partial writes leave other lanes alone
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // ****************************************************************
  // carrier generator
  // ****************************************************************
  irc_carrier u_carrier (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .run_in(st_q.car_run),
    .mod_in(st_q.cfg),
    .level_out(car_level),
    .hi_end_out(car_hi_end)
  );

  // ****************************************************************
  // register read view
  // ****************************************************************

  // unmapped offsets read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (AVS_ADDRESS_IN)
      `IRC_OFF_TIMER: begin
        rd_mux[8:0] = st_q.cnt;
        rd_mux[`IRC_TMR_EN_BIT] = st_q.en;
        rd_mux[`IRC_TMR_RUN_BIT] = (st_q.cnt != 9'h000);
        rd_mux[`IRC_TMR_PIN_BIT] = st_q.pin;
      end
      `IRC_OFF_HIMOD: begin
        rd_mux[8:0] = st_q.cfg.hi;
        rd_mux[`IRC_CAR_DIS_BIT] = st_q.cfg.dis;
      end
      `IRC_OFF_LOMOD: begin
        rd_mux[8:0] = st_q.cfg.lo; // bit nine stays zero
      end
      `IRC_OFF_CTRL: begin
        rd_mux[`IRC_CTRL_HS_BIT] = st_q.hs;
        rd_mux[`IRC_CTRL_STOP_BIT] = st_q.stop;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // write takes effect at the edge where waitrequest is seen low
  assign wr_fire = (st_q.bus == IRC_BUS_ACK) && AVS_WRITE_IN;
  assign wd = be_merge(rd_mux, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb begin
    st_d = st_q;

    // bus handshake: one wait cycle, then one ready cycle
    case (st_q.bus)
      IRC_BUS_IDLE: begin
        if (AVS_READ_IN || AVS_WRITE_IN) begin
          st_d.bus = IRC_BUS_ACK;
          st_d.wait_req = 1'b0;
          st_d.rdata = rd_mux;
        end
      end
      IRC_BUS_ACK: begin
        st_d.bus = IRC_BUS_IDLE;
        st_d.wait_req = 1'b1;
      end
      default: begin
        st_d.bus = IRC_BUS_IDLE;
        st_d.wait_req = 1'b1;
      end
    endcase

    // down counter; runs whether or not the cpu is halted
    if (st_q.cnt != 9'h000) begin
      if (st_q.presc == 8'h00) begin
        st_d.cnt = st_q.cnt - 9'h001;
        st_d.presc = PRESC_RELOAD;
      end else begin
        st_d.presc = st_q.presc - 8'h01;
      end
    end

    // register writes; a timer write outside stop mode restarts the count
    if (wr_fire) begin
      case (AVS_ADDRESS_IN)
        `IRC_OFF_TIMER: begin
          if (!st_q.stop) begin
            st_d.cnt = wd[8:0];
            st_d.en = wd[`IRC_TMR_EN_BIT];
            // the first step sets the 4 or 2 period start loss of the total
            st_d.presc = st_q.hs ? FIRST_HS : FIRST_NORM;
          end
        end
        `IRC_OFF_HIMOD: begin
          st_d.cfg.hi = wd[8:0];
          st_d.cfg.dis = wd[`IRC_CAR_DIS_BIT];
        end
        `IRC_OFF_LOMOD: begin
          st_d.cfg.lo = wd[8:0];
        end
        `IRC_OFF_CTRL: begin
          st_d.hs = wd[`IRC_CTRL_HS_BIT];
          st_d.stop = wd[`IRC_CTRL_STOP_BIT];
        end
        default: begin
          st_d.cnt = st_d.cnt;
        end
      endcase
    end

    // stop mode: oscillator gone, so the timer is halted and cleared
    if (st_q.stop) begin
      st_d.cnt = 9'h000;
      st_d.en = 1'b0;
      st_d.presc = 8'h00;
    end

    // carrier keeps running after zero only to finish a high phase
    st_d.car_run = !st_q.stop &&
      (((st_q.cnt != 9'h000) && st_q.en && !st_q.cfg.dis) ||
       (st_q.car_run && car_level && !car_hi_end));

    // pin selection
    if (st_q.stop) begin
      st_d.pin = 1'b0;
    end else if ((st_q.cnt != 9'h000) && st_q.en) begin
      // gated by car_run so a restart on a phase flip still opens low
      st_d.pin = st_q.cfg.dis ? 1'b1 : (st_q.car_run && car_level);
    end else begin
      st_d.pin = st_q.car_run && car_level;
    end

    // indicator is low while the timer runs with output enabled
    st_d.ind_n = !((st_q.cnt != 9'h000) && st_q.en);
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      st_q.bus <= IRC_BUS_IDLE;
      st_q.wait_req <= 1'b1;
      st_q.rdata <= 32'h0000_0000;
      st_q.cnt <= 9'h000;
      st_q.en <= 1'b0;
      st_q.presc <= 8'h00;
      st_q.hs <= 1'b0;
      st_q.stop <= 1'b0;
      st_q.cfg.dis <= 1'(`IRC_HIMOD_RST >> `IRC_CAR_DIS_BIT);
      st_q.cfg.hi <= 9'(`IRC_HIMOD_RST);
      st_q.cfg.lo <= `IRC_LOMOD_RST;
      st_q.car_run <= 1'b0;
      st_q.pin <= 1'b0;
      st_q.ind_n <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state flops
  assign AVS_READDATA_OUT = st_q.rdata;
  assign AVS_WAITREQUEST_OUT = st_q.wait_req;
  assign IR_OUTPUT_PIN_OUT = st_q.pin;
  assign SENSE_INDICATOR_PIN_N_OUT = st_q.ind_n;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);

  AST_PIN_LOW_IDLE: assert property (
    (st_q.cnt == 9'h000 && !(st_q.car_run && car_level)) |=> !IR_OUTPUT_PIN_OUT)
    else $error("pin high while counter zero and no high phase pending");

  AST_STEADY_HIGH: assert property (
    (st_q.cnt != 9'h000 && st_q.en && st_q.cfg.dis && !st_q.stop) |=> IR_OUTPUT_PIN_OUT)
    else $error("pin not steady high with carrier disabled");

  AST_START_LOW: assert property (
    $rose(st_q.car_run) |-> !car_level ##1 !IR_OUTPUT_PIN_OUT)
    else $error("carrier did not start in the low phase");

  AST_STOP_LOW: assert property (
    (st_q.car_run && !car_level && st_q.cnt == 9'h000) |=>
      !st_q.car_run ##1 !IR_OUTPUT_PIN_OUT)
    else $error("carrier kept running after count reached zero");

  AST_HIGH_KEPT: assert property (
    (st_q.cnt == 9'h000 && st_q.car_run && car_level && !car_hi_end && !st_q.stop) |=>
      st_q.car_run && car_level && IR_OUTPUT_PIN_OUT)
    else $error("high phase cut short at count zero");

  AST_DEC_STEP: assert property (
    (st_q.cnt != 9'h000 && st_q.presc == 8'h00 && !wr_fire && !st_q.stop) |=>
      (st_q.cnt == $past(st_q.cnt) - 9'h001) && (st_q.presc == PRESC_RELOAD))
    else $error("down counter did not step on prescaler expiry");

  AST_STOP_CLEAR: assert property (
    st_q.stop |=> (st_q.cnt == 9'h000) && !st_q.en ##1 !IR_OUTPUT_PIN_OUT)
    else $error("stop mode left the timer running");

  AST_FIRST_NORM: assert property (
    (wr_fire && AVS_ADDRESS_IN == `IRC_OFF_TIMER && !st_q.hs && !st_q.stop) |=>
      st_q.presc == FIRST_NORM)
    else $error("normal start did not load the shortened first step");

  AST_FIRST_HS: assert property (
    (wr_fire && AVS_ADDRESS_IN == `IRC_OFF_TIMER && st_q.hs && !st_q.stop) |=>
      st_q.presc == FIRST_HS)
    else $error("high speed start did not load its first step");

  AST_LO_BIT9: assert property (
    (st_q.bus == IRC_BUS_IDLE && AVS_READ_IN && AVS_ADDRESS_IN == `IRC_OFF_LOMOD) |=>
      !AVS_WAITREQUEST_OUT && !AVS_READDATA_OUT[9])
    else $error("low modulo bit nine read back as one");

  // indicator, counter, carrier start and stop-mode pin bookkeeping
  AST_IND_ACTIVE: assert property (
    (st_q.cnt != 9'h000 && st_q.en) |=> !SENSE_INDICATOR_PIN_N_OUT)
    else $error("indicator not driven while the timer runs");

  AST_IND_IDLE: assert property (
    !(st_q.cnt != 9'h000 && st_q.en) |=> SENSE_INDICATOR_PIN_N_OUT)
    else $error("indicator driven while the timer is idle");

  AST_ZERO_HOLD: assert property (
    (st_q.cnt == 9'h000 && !wr_fire) |=> st_q.cnt == 9'h000)
    else $error("down counter left zero without a timer write");

  AST_PRESC_STEP: assert property (
    (st_q.cnt != 9'h000 && st_q.presc != 8'h00 && !wr_fire && !st_q.stop) |=>
      (st_q.presc == $past(st_q.presc) - 8'h01) && (st_q.cnt == $past(st_q.cnt)))
    else $error("prescaler or count moved off its step");

  AST_DIS_NO_CARRIER: assert property (
    (st_q.cfg.dis && !st_q.car_run) |=> !st_q.car_run)
    else $error("carrier started while disabled");

  AST_EN_NO_CARRIER: assert property (
    (!st_q.en && !st_q.car_run) |=> !st_q.car_run)
    else $error("carrier started with output enable clear");

  AST_TIMER_LOAD: assert property (
    (wr_fire && AVS_ADDRESS_IN == `IRC_OFF_TIMER && !st_q.stop) |=>
      (st_q.cnt == $past(wd[8:0])) && (st_q.en == $past(wd[`IRC_TMR_EN_BIT])))
    else $error("timer write did not load count and enable");

  AST_STOP_PIN: assert property (
    st_q.stop |=> !IR_OUTPUT_PIN_OUT)
    else $error("pin driven in stop mode");

  COV_CARRIER: cover property ($rose(st_q.car_run) ##[1:300] car_level);
  COV_TAIL: cover property (st_q.cnt == 9'h000 && car_hi_end);
  COV_STEADY: cover property (st_q.cnt != 9'h000 && st_q.en && st_q.cfg.dis);
  COV_STOP: cover property (st_q.stop && st_q.cnt != 9'h000);

endmodule : irc_top

`default_nettype wire

// ---- src/irc_map.svh ----
// register offsets, field positions, reset values and timing figures of the ir carrier block
`ifndef IRC_MAP_SVH
`define IRC_MAP_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define IRC_OFF_TIMER 4'h0
`define IRC_OFF_HIMOD 4'h4
`define IRC_OFF_LOMOD 4'h8
`define IRC_OFF_CTRL 4'hC

// ****************************************************************
// field positions
// ****************************************************************
`define IRC_TMR_EN_BIT 9
`define IRC_TMR_RUN_BIT 10
`define IRC_TMR_PIN_BIT 11
`define IRC_CAR_DIS_BIT 9
`define IRC_CTRL_HS_BIT 0
`define IRC_CTRL_STOP_BIT 1

// ****************************************************************
// reset values
// ****************************************************************
`define IRC_HIMOD_RST 10'h001
`define IRC_LOMOD_RST 9'h001

// ****************************************************************
// timing: clocks per system period, then figures in system clock periods
// ****************************************************************
`define IRC_CLK_PER_FX 2
`define IRC_DEC_FX 64
`define IRC_LOSS_NORM_FX 4
`define IRC_HS_HALF_FX 32
`define IRC_LOSS_HS_FX 2

`endif

// ---- src/irc_pkg.sv ----
// types shared by the ir carrier output block
package irc_pkg;

  // ****************************************************************
  // carrier configuration
  // ****************************************************************
  typedef struct packed {
    logic dis;
    logic [8:0] hi;
    logic [8:0] lo;
  } irc_mod_t;

  // ****************************************************************
  // bus handshake states
  // ****************************************************************
  typedef enum logic {IRC_BUS_IDLE, IRC_BUS_ACK} irc_bus_st_t;

  // ****************************************************************
  // module state records
  // ****************************************************************
  typedef struct packed {
    logic level;
    logic [8:0] cnt;
  } irc_car_st_t;

  typedef struct packed {
    irc_bus_st_t bus;
    logic wait_req;
    logic [31:0] rdata;
    logic [8:0] cnt;
    logic en;
    logic [7:0] presc;
    logic hs;
    logic stop;
    irc_mod_t cfg;
    logic car_run;
    logic pin;
    logic ind_n;
  } irc_top_st_t;

endpackage : irc_pkg

// ---- src/irc_carrier.sv ----
// carrier period counter with separate high and low phase lengths
`timescale 1ns/1ps
`default_nettype none

module irc_carrier
  import irc_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // control
  input wire logic run_in,
  input wire irc_mod_t mod_in,
  // carrier
  output logic level_out,
  output logic hi_end_out
);

  irc_car_st_t st_q;
  irc_car_st_t st_d;

  // ****************************************************************
  // phase counter
  // ****************************************************************

  // one count per clock, the clock standing for twice the system rate
  always_comb begin
    st_d = st_q;
    if (!run_in) begin
      // parked in the low phase so a start always opens low
      st_d.level = 1'b0;
      st_d.cnt = mod_in.lo;
    end else if (st_q.cnt == 9'h000) begin
      st_d.level = !st_q.level;
      st_d.cnt = st_q.level ? mod_in.lo : mod_in.hi;
    end else begin
      st_d.cnt = st_q.cnt - 9'h001;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs
  assign level_out = st_q.level;
  assign hi_end_out = run_in && st_q.level && (st_q.cnt == 9'h000);

  // ****************************************************************
  // checks
  // ****************************************************************
  AST_PHASE_FLIP: assert property (@(posedge clk_in) disable iff (rst_in)
    (run_in && st_q.cnt == 9'h000) ##1 run_in |->
      (st_q.level != $past(st_q.level)))
    else $error("carrier phase did not flip at terminal count");

  AST_PHASE_LEN: assert property (@(posedge clk_in) disable iff (rst_in)
    (run_in && st_q.cnt == 9'h002) ##1 run_in |-> st_q.cnt == 9'h001 ##1 st_q.cnt == 9'h000)
    else $error("carrier counter did not step once per clock");

endmodule : irc_carrier

`default_nettype wire

// ---- dv/irc_led_model.sv ----
// behavioural infrared led driver stage that watches the output pin
`timescale 1ns/1ps
`default_nettype none

module irc_led_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // pin from the block
  input wire logic pin_in,
  // pulse statistics
  output logic [15:0] rises_out,
  output logic [15:0] falls_out,
  output logic [15:0] hi_len_out,
  output logic [15:0] lo_len_out
);
  logic [15:0] run_q;
  logic last_q;

  // ****************************************************************
  // run-length measurement of the led drive
  // ****************************************************************
  // the stage is a pure sink; it only measures what it is given
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      run_q <= 16'h0001;
      last_q <= 1'b0;
      rises_out <= 16'h0000;
      falls_out <= 16'h0000;
      hi_len_out <= 16'h0000;
      lo_len_out <= 16'h0000;
    end else begin
      last_q <= pin_in;
      if (pin_in !== last_q) begin
        run_q <= 16'h0001;
        if (pin_in === 1'b1) begin
          rises_out <= rises_out + 16'h0001;
          lo_len_out <= run_q;
        end else begin
          falls_out <= falls_out + 16'h0001;
          hi_len_out <= run_q;
        end
      end else begin
        run_q <= run_q + 16'h0001; // a stuck pin wraps the count to zero after 65535 clocks
      end
    end
  end
endmodule : irc_led_model
`default_nettype wire

// ---- dv/irc_top_tb.sv ----
// self-checking bench for the ir carrier output block
`timescale 1ns/1ps
`default_nettype none
`include "irc_map.svh"

module irc_top_tb
  import irc_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic wait_req;
  logic pin;
  logic ind_n;
  logic [15:0] rises, falls, hi_len, lo_len;
  logic [31:0] q;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;

  // ****************************************************************
  // clock, design and partner
  // ****************************************************************
  always #20 clk = ~clk;

  irc_top dut (.CLK_IN(clk), .RST_IN(rst), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd_en),
    .AVS_WRITE_IN(wr_en), .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(4'hF),
    .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wait_req),
    .IR_OUTPUT_PIN_OUT(pin), .SENSE_INDICATOR_PIN_N_OUT(ind_n));

  irc_led_model led (.clk_in(clk), .rst_in(rst), .pin_in(pin), .rises_out(rises),
    .falls_out(falls), .hi_len_out(hi_len), .lo_len_out(lo_len));

  // ****************************************************************
  // verdict, checks and watchdog
  // ****************************************************************
  task automatic report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // ceiling well above the few thousand clocks the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  // ****************************************************************
  // avalon-mm master: hold request until waitrequest sampled low
  // ****************************************************************
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= wr;
    rd_en <= ~wr;
    do @(posedge clk); while (wait_req !== 1'b0);
    q = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [3:0] a);
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd

  // wait, bounded by the watchdog, for the pin's fall count to reach a given total, then two more clocks
  task automatic wait_falls(input logic [15:0] target);
    while (falls < target) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask : wait_falls

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [15:0] f0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // reset state of pins and registers
    chk({30'h0, pin, ind_n}, 32'h0000_0001);
    rd(`IRC_OFF_HIMOD);
    chk(q, 32'h0000_0001);
    rd(`IRC_OFF_LOMOD);
    chk(q, 32'h0000_0001);
    rd(`IRC_OFF_CTRL);
    chk(q, 32'h0000_0000);
    rd(`IRC_OFF_TIMER);
    chk(q, 32'h0000_0000);
    rd(4'h2);
    chk(q, 32'h0000_0000);
    // low modulo bit nine cannot be set
    wr(`IRC_OFF_LOMOD, 32'h0000_0205);
    rd(`IRC_OFF_LOMOD);
    chk(q, 32'h0000_0005);
    // carrier hi=3 lo=5, loaded before the timer starts
    wr(`IRC_OFF_HIMOD, 32'h0000_0003);
    f0 = rises;
    wr(`IRC_OFF_TIMER, 32'h0000_0202);
    repeat (4) @(posedge clk);
    chk({31'h0, pin}, 32'h0);
    chk({16'h0, rises}, {16'h0, f0});
    chk({31'h0, ind_n}, 32'h0);
    wait_falls(falls + 16'h0003);
    chk({16'h0, hi_len}, 32'h0000_0004);
    chk({16'h0, lo_len}, 32'h0000_0006);
    rd(`IRC_OFF_TIMER);
    chk({30'h0, q[10:9]}, 32'h0000_0003);
    // count runs out after 376 clocks; pin must settle low
    repeat (400) @(posedge clk);
    rd(`IRC_OFF_TIMER);
    chk({20'h0, q[11:0]}, 32'h0000_0200);
    chk({30'h0, pin, ind_n}, 32'h0000_0001);
    // longest high phase spans the zero of the count and is not cut
    wr(`IRC_OFF_HIMOD, 32'h0000_01FF);
    wr(`IRC_OFF_LOMOD, 32'h0000_0001);
    f0 = falls;
    wr(`IRC_OFF_TIMER, 32'h0000_0201);
    wait_falls(f0 + 16'h0001);
    chk({16'h0, hi_len}, 32'h0000_0200);
    repeat (20) @(posedge clk);
    chk({16'h0, falls}, {16'h0, f0 + 16'h0001});
    // steady high: output lasts (n+1)*64-4 system periods
    wr(`IRC_OFF_HIMOD, 32'h0000_0201);
    f0 = falls;
    wr(`IRC_OFF_TIMER, 32'h0000_0201);
    wait_falls(f0 + 16'h0001);
    chk({16'h0, hi_len}, 32'h0000_00F8);
    // first step 248 clocks, then 128 each: count is 2 from 248 to 376
    wr(`IRC_OFF_TIMER, 32'h0000_0203);
    repeat (260) @(posedge clk);
    rd(`IRC_OFF_TIMER);
    chk({23'h0, q[8:0]}, 32'h0000_0002);
    wait_falls(falls + 16'h0001);
    chk({16'h0, hi_len}, 32'h0000_01F8);
    // high-speed mode: (n+0.5)*64-2 system periods
    wr(`IRC_OFF_CTRL, 32'h0000_0001);
    f0 = falls;
    wr(`IRC_OFF_TIMER, 32'h0000_0201);
    wait_falls(f0 + 16'h0001);
    chk({16'h0, hi_len}, 32'h0000_00BC);
    wr(`IRC_OFF_CTRL, 32'h0000_0000);
    // enable clear keeps the pin low though the count runs
    f0 = rises;
    wr(`IRC_OFF_TIMER, 32'h0000_0002);
    repeat (50) @(posedge clk);
    rd(`IRC_OFF_TIMER);
    chk({29'h0, q[11:9]}, 32'h0000_0002);
    chk({15'h0, ind_n, rises}, {15'h0, 1'b1, f0});
    // stop mode halts and clears the timer, and ignores timer writes
    wr(`IRC_OFF_TIMER, 32'h0000_0205);
    repeat (10) @(posedge clk);
    chk({31'h0, pin}, 32'h0000_0001);
    wr(`IRC_OFF_CTRL, 32'h0000_0002);
    repeat (3) @(posedge clk);
    rd(`IRC_OFF_TIMER);
    chk({20'h0, q[11:0]}, 32'h0000_0000);
    wr(`IRC_OFF_TIMER, 32'h0000_0203);
    rd(`IRC_OFF_TIMER);
    chk({20'h0, q[11:0]}, 32'h0000_0000);
    chk({31'h0, pin}, 32'h0);
    wr(`IRC_OFF_CTRL, 32'h0000_0000);
    // a count of zero with enable set never drives the pin
    wr(`IRC_OFF_TIMER, 32'h0000_0200);
    repeat (5) @(posedge clk);
    chk({30'h0, pin, ind_n}, 32'h0000_0001);
    report_and_stop();
  end
endmodule : irc_top_tb
`default_nettype wire
